// [rtl/hmcf_pkg.sv]
// hmcf_pkg: constants, opcodes and state types shared by both link ends
// assumes a single 125 MHz system clock at each end; no imports anywhere
//
// How it works
// - discriminator input is 1 at/above threshold
// - hit is discriminator AND channel mask
// - controller loads mask over link; device stores
// - link carries fundamental clock with interleaved data
// - counter reset command exact within one cycle
// - inject command fires at precise clock time
// - device holds 6-bit threshold DAC setting
// - logic runs at nominal 10 MHz fundamental
// - all device logic clocked by CLK_SYS, acting on synchronised link clock rises
// - sixty-four independent channels with own mask
// - optional diagnostic register replaces live hits
// - discriminator state sampled on rising edge
// - one hit per pulse, no time-over-threshold
package hmcf_pkg;

  // timing
  localparam int CLK_PERIOD_NS  = 8;
  localparam int FUND_PERIOD_NS = 100;
  localparam int FUND_DIV       = FUND_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [3:0] DIV_LAST = 4'(FUND_DIV - 1);
  localparam logic [3:0] DIV_HALF = 4'(FUND_DIV / 2 - 1);

  // widths
  localparam int N_CHAN = 64;
  localparam int THR_W  = 6;
  localparam int OP_W   = 3;

  // frame counts
  localparam logic [6:0] OP_LAST   = 7'h02;
  localparam logic [6:0] HDR_LEN   = 7'h04;
  localparam logic [6:0] RESP_LAST = 7'h41;
  localparam logic [5:0] RX_LAST   = 6'h3F;

  // values after reset
  localparam logic [63:0] MASK_RST = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [5:0]  THR_RST  = 6'h20;
  localparam logic [63:0] DIAG_RST = 64'h0;

  // opcodes, sent LSB first after a start bit
  localparam logic [2:0] OP_NOP    = 3'h0;
  localparam logic [2:0] OP_CRST   = 3'h1;
  localparam logic [2:0] OP_INJ    = 3'h2;
  localparam logic [2:0] OP_MASK   = 3'h3;
  localparam logic [2:0] OP_THR    = 3'h4;
  localparam logic [2:0] OP_DIAG   = 3'h5;
  localparam logic [2:0] OP_DIAGEN = 3'h6;
  localparam logic [2:0] OP_READ   = 3'h7;

  // payload length in bits for an opcode
  function automatic logic [6:0] hmcf_plen(input logic [2:0] op);
    case (op)
      OP_MASK:   hmcf_plen = 7'h40;
      OP_DIAG:   hmcf_plen = 7'h40;
      OP_THR:    hmcf_plen = 7'h06;
      OP_DIAGEN: hmcf_plen = 7'h01;
      default:   hmcf_plen = 7'h00;
    endcase
  endfunction

  typedef enum logic [3:0] {
    DEV_IDLE = 4'h1,
    DEV_OPC  = 4'h2,
    DEV_PAY  = 4'h4,
    DEV_RESP = 4'h8
  } hmcf_dev_state_t;

  typedef enum logic [2:0] {
    CTL_IDLE = 3'h1,
    CTL_SEND = 3'h2,
    CTL_RECV = 3'h4
  } hmcf_ctl_state_t;

endpackage

// [rtl/hmcf_link_if.sv]
// hmcf_link_if: the three-wire control link between controller and device
// assumes both ends share CLK_SYS; all wires are single-direction
`timescale 1ns/1ns
`default_nettype none
interface hmcf_link_if;
  logic link_clk;
  logic link_cmd;
  logic link_rsp;

  modport ctrl (output link_clk, output link_cmd, input link_rsp);
  modport dev  (input link_clk, input link_cmd, output link_rsp);
endinterface
`default_nettype wire

// [rtl/hmcf_device.sv]
// hmcf_device: hit sampling, masking and the device end of the control link
// assumes link pins and discriminator lines are asynchronous to CLK_SYS
// and that CLK_SYS is well above eight times the fundamental link clock
`timescale 1ns/1ns
`default_nettype none
module hmcf_device (
  // system
  input  wire logic        CLK_SYS,
  input  wire logic        RESETN,
  input  wire logic        CE,
  // control link
  hmcf_link_if.dev         LINK,
  // discriminator outputs, 1 when at or above threshold
  input  wire logic [63:0] DISC_IN,
  // recorded hits
  output logic      [63:0] HIT,
  output logic             HIT_STB,
  // analog and timing controls
  output logic      [5:0]  THRESH,
  output logic             CNT_RESET,
  output logic             INJECT,
  output logic             DIAG_ON
);

  // link synchronisers; the stage-1 flops feed only stage 2
  logic        clk_s1_q;
  logic        clk_s2_q;
  logic        clk_s3_q;
  logic        cmd_s1_q;
  logic        cmd_s2_q;
  logic [63:0] disc_s1_q;
  logic [63:0] disc_s2_q;
  logic [63:0] disc_prev_q;

  // frame decoder
  hmcf_pkg::hmcf_dev_state_t state_q;
  logic [2:0]  opc_q;
  logic [6:0]  cnt_q;
  logic [63:0] sr_q;
  logic [63:0] sr_d;
  logic [2:0]  op_d;

  // settings and outputs
  logic [63:0] mask_q;
  logic [5:0]  thr_q;
  logic [63:0] diag_q;
  logic        diag_en_q;
  logic        rsp_q;
  logic [63:0] hit_q;
  logic        stb_q;
  logic        crst_q;
  logic        inj_q;

  // decoded events
  logic        tick;
  logic        op_end;
  logic        pay_end;
  logic [63:0] hit_src;

  // synchronise link and discriminator pins
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      clk_s1_q  <= 1'b0;
      clk_s2_q  <= 1'b0;
      clk_s3_q  <= 1'b0;
      cmd_s1_q  <= 1'b0;
      cmd_s2_q  <= 1'b0;
      disc_s1_q <= 64'h0;
      disc_s2_q <= 64'h0;
    end
    else if (CE)
    begin
      clk_s1_q  <= LINK.link_clk;
      clk_s2_q  <= clk_s1_q;
      clk_s3_q  <= clk_s2_q;
      cmd_s1_q  <= LINK.link_cmd;
      cmd_s2_q  <= cmd_s1_q;
      disc_s1_q <= DISC_IN;
      disc_s2_q <= disc_s1_q;
    end
  end

  // every action happens on a rising edge of the link clock
  assign tick = clk_s2_q & ~clk_s3_q;

  // decode helpers; data and clock share the same sync delay
  always_comb
  begin
    sr_d    = {cmd_s2_q, sr_q[63:1]};
    op_d    = {cmd_s2_q, opc_q[2:1]};
    op_end  = tick && (state_q == hmcf_pkg::DEV_OPC) && (cnt_q == hmcf_pkg::OP_LAST);
    pay_end = tick && (state_q == hmcf_pkg::DEV_PAY)
              && (cnt_q == hmcf_pkg::hmcf_plen(opc_q) - 7'h01);
  end

  // frame state machine: start bit, 3 opcode bits, payload or reply
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      state_q <= hmcf_pkg::DEV_IDLE;
      opc_q   <= 3'h0;
      cnt_q   <= 7'h00;
      sr_q    <= 64'h0;
    end
    else if (CE && tick)
    begin
      case (state_q)
        hmcf_pkg::DEV_IDLE:
        begin
          cnt_q <= 7'h00;
          if (cmd_s2_q)
            state_q <= hmcf_pkg::DEV_OPC;
        end
        hmcf_pkg::DEV_OPC:
        begin
          opc_q <= op_d;
          cnt_q <= (cnt_q == hmcf_pkg::OP_LAST) ? 7'h00 : cnt_q + 7'h01;
          if (cnt_q == hmcf_pkg::OP_LAST)
          begin
            if (op_d == hmcf_pkg::OP_READ)
              state_q <= hmcf_pkg::DEV_RESP;
            else if (hmcf_pkg::hmcf_plen(op_d) != 7'h00)
              state_q <= hmcf_pkg::DEV_PAY;
            else
              state_q <= hmcf_pkg::DEV_IDLE;
          end
        end
        hmcf_pkg::DEV_PAY:
        begin
          sr_q  <= sr_d;
          cnt_q <= cnt_q + 7'h01;
          if (pay_end)
            state_q <= hmcf_pkg::DEV_IDLE;
        end
        hmcf_pkg::DEV_RESP:
        begin
          cnt_q <= cnt_q + 7'h01;
          if (cnt_q == hmcf_pkg::RESP_LAST)
            state_q <= hmcf_pkg::DEV_IDLE;
        end
        default:
          state_q <= hmcf_pkg::DEV_IDLE;
      endcase
    end
  end

  // reply: a start bit, then mask LSB first, then one idle bit
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
      rsp_q <= 1'b0;
    else if (CE && tick)
    begin
      if (state_q != hmcf_pkg::DEV_RESP)
        rsp_q <= 1'b0;
      else if (cnt_q == 7'h00)
        rsp_q <= 1'b1;
      else if (cnt_q == hmcf_pkg::RESP_LAST)
        rsp_q <= 1'b0;
      else
        rsp_q <= mask_q[6'(cnt_q - 7'h01)];
    end
  end

  // settings land whole on one tick, so hits see old or new only
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      mask_q    <= hmcf_pkg::MASK_RST;
      thr_q     <= hmcf_pkg::THR_RST;
      diag_q    <= hmcf_pkg::DIAG_RST;
      diag_en_q <= 1'b0;
    end
    else if (CE && pay_end)
    begin
      case (opc_q)
        hmcf_pkg::OP_MASK:   mask_q    <= sr_d;
        hmcf_pkg::OP_THR:    thr_q     <= sr_d[63:58];
        hmcf_pkg::OP_DIAG:   diag_q    <= sr_d;
        hmcf_pkg::OP_DIAGEN: diag_en_q <= sr_d[63];
        default:             diag_en_q <= diag_en_q;
      endcase
    end
  end

  // timing commands: fixed latency from the last opcode bit
  // so every chip on the link fires on the same fundamental edge
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      crst_q <= 1'b0;
      inj_q  <= 1'b0;
    end
    else if (CE)
    begin
      crst_q <= op_end && (op_d == hmcf_pkg::OP_CRST);
      inj_q  <= op_end && (op_d == hmcf_pkg::OP_INJ);
    end
  end

  // hit source: diagnostic pattern replaces live leading edges
  // leading-edge only, so a slow recovery cannot record twice
  assign hit_src = diag_en_q ? diag_q : (disc_s2_q & ~disc_prev_q);

  // sample all channels on the fundamental rising edge
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      disc_prev_q <= 64'h0;
      hit_q       <= 64'h0;
      stb_q       <= 1'b0;
    end
    else if (CE)
    begin
      stb_q <= tick;
      if (tick)
      begin
        disc_prev_q <= disc_s2_q;
        hit_q       <= hit_src & mask_q;
      end
    end
  end

  // outputs straight from flops
  assign LINK.link_rsp = rsp_q;
  assign HIT           = hit_q;
  assign HIT_STB       = stb_q;
  assign THRESH        = thr_q;
  assign CNT_RESET     = crst_q;
  assign INJECT        = inj_q;
  assign DIAG_ON       = diag_en_q;

endmodule
`default_nettype wire

// [rtl/hmcf_controller.sv]
// hmcf_controller: the system-controller end of the control link
// assumes its user side is on CLK_SYS; the reply pin is asynchronous
`timescale 1ns/1ns
`default_nettype none
module hmcf_controller (
  // system
  input  wire logic        CLK_SYS,
  input  wire logic        RESETN,
  input  wire logic        CE,
  // control link
  hmcf_link_if.ctrl        LINK,
  // command request
  input  wire logic        REQ,
  input  wire logic [2:0]  OPCODE,
  input  wire logic [63:0] DATA,
  output logic             READY,
  output logic             DONE,
  // read reply
  output logic      [63:0] RDATA,
  output logic             RVALID
);

  hmcf_pkg::hmcf_ctl_state_t state_q;
  logic [3:0]  div_q;
  logic        lclk_q;
  logic        cmd_q;
  logic [67:0] tx_q;
  logic [6:0]  left_q;
  logic [2:0]  op_q;
  logic        rsp_s1_q;
  logic        rsp_s2_q;
  logic        got_q;
  logic [5:0]  k_q;
  logic [63:0] rx_q;
  logic        ready_q;
  logic        done_q;
  logic        rvalid_q;
  logic        rise;
  logic        fall;

  // edge strobes, decoded one cycle ahead of the link clock pin
  assign rise = (div_q == hmcf_pkg::DIV_LAST);
  assign fall = (div_q == hmcf_pkg::DIV_HALF);

  // divide the system clock down to the fundamental link clock
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      div_q  <= 4'h0;
      lclk_q <= 1'b0;
    end
    else if (CE)
    begin
      div_q <= rise ? 4'h0 : div_q + 4'h1;
      if (rise)
        lclk_q <= 1'b1;
      else if (fall)
        lclk_q <= 1'b0;
    end
  end

  // reply pin synchroniser
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      rsp_s1_q <= 1'b0;
      rsp_s2_q <= 1'b0;
    end
    else if (CE)
    begin
      rsp_s1_q <= LINK.link_rsp;
      rsp_s2_q <= rsp_s1_q;
    end
  end

  // data changes on the falling half, far from the device's sample
  // a missing reply leaves the end stuck in receive until reset
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      state_q  <= hmcf_pkg::CTL_IDLE;
      cmd_q    <= 1'b0;
      tx_q     <= 68'h0;
      left_q   <= 7'h00;
      op_q     <= 3'h0;
      got_q    <= 1'b0;
      k_q      <= 6'h00;
      rx_q     <= 64'h0;
      ready_q  <= 1'b1;
      done_q   <= 1'b0;
      rvalid_q <= 1'b0;
    end
    else if (CE)
    begin
      done_q   <= 1'b0;
      rvalid_q <= 1'b0;
      case (state_q)
        hmcf_pkg::CTL_IDLE:
        begin
          if (REQ && ready_q)
          begin
            tx_q    <= {DATA, OPCODE, 1'b1};
            left_q  <= hmcf_pkg::HDR_LEN + hmcf_pkg::hmcf_plen(OPCODE);
            op_q    <= OPCODE;
            ready_q <= 1'b0;
            state_q <= hmcf_pkg::CTL_SEND;
          end
        end
        hmcf_pkg::CTL_SEND:
        begin
          if (fall && left_q == 7'h00)
          begin
            cmd_q <= 1'b0;
            got_q <= 1'b0;
            k_q   <= 6'h00;
            if (op_q == hmcf_pkg::OP_READ)
              state_q <= hmcf_pkg::CTL_RECV;
            else
            begin
              done_q  <= 1'b1;
              ready_q <= 1'b1;
              state_q <= hmcf_pkg::CTL_IDLE;
            end
          end
          else if (fall)
          begin
            cmd_q  <= tx_q[0];
            tx_q   <= {1'b0, tx_q[67:1]};
            left_q <= left_q - 7'h01;
          end
        end
        hmcf_pkg::CTL_RECV:
        begin
          if (rise && !got_q)
            got_q <= rsp_s2_q;
          else if (rise)
          begin
            rx_q <= {rsp_s2_q, rx_q[63:1]};
            k_q  <= k_q + 6'h01;
            if (k_q == hmcf_pkg::RX_LAST)
            begin
              rvalid_q <= 1'b1;
              done_q   <= 1'b1;
              ready_q  <= 1'b1;
              state_q  <= hmcf_pkg::CTL_IDLE;
            end
          end
        end
        default:
          state_q <= hmcf_pkg::CTL_IDLE;
      endcase
    end
  end

  assign LINK.link_clk = lclk_q;
  assign LINK.link_cmd = cmd_q;
  assign READY         = ready_q;
  assign DONE          = done_q;
  assign RDATA         = rx_q;
  assign RVALID        = rvalid_q;

endmodule
`default_nettype wire

// [tb/hmcf_link_properties.sv]
// hmcf_link_chk: timing checks on the three control link wires
// assumes CLK_SYS and RESETN are shared by both link ends
`timescale 1ns/1ns
`default_nettype none
module hmcf_link_chk (
  // system
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // link wires
  input wire logic link_clk,
  input wire logic link_cmd,
  input wire logic link_rsp
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESETN);

  // fundamental clock: six cycles high, then six low
  AST_CLK_HI: assert property ($rose(link_clk) |-> link_clk [*6] ##1 !link_clk)
    else $error("link clock high phase has wrong length");
  AST_CLK_LO: assert property ($fell(link_clk) |-> !link_clk [*6] ##1 link_clk)
    else $error("link clock low phase has wrong length");
  // command bits move in the low phase, so the rise samples a settled bit
  AST_CMD_PHASE: assert property ($changed(link_cmd) |-> !link_clk)
    else $error("command bit moved while link clock high");
  AST_CMD_HOLD: assert property ($changed(link_cmd) |=> $stable(link_cmd) [*8])
    else $error("command bit held too briefly");
  AST_RSP_HOLD: assert property ($changed(link_rsp) |=> $stable(link_rsp) [*8])
    else $error("reply bit held too briefly");
  // all wires quiet just after reset
  AST_RST_CLK: assert property ($rose(RESETN) |-> !link_clk [*8])
    else $error("link clock started too early");
  AST_RST_CMD: assert property ($rose(RESETN) |-> !link_cmd [*8])
    else $error("command line not idle after reset");
  AST_RST_RSP: assert property ($rose(RESETN) |-> !link_rsp [*8])
    else $error("reply line not idle after reset");
endmodule
`default_nettype wire

// [tb/hmcf_tb.sv]
// hmcf_tb: controller and device joined by one link, driven from user side
// assumes the hand-over timing of both ends; CE is held high throughout
`timescale 1ns/1ns
`default_nettype none
module hmcf_tb;
  logic        clk_sys;
  logic        resetn;
  logic        req;
  logic [2:0]  opcode;
  logic [63:0] data;
  logic [63:0] disc_in;
  logic        ready;
  logic        done;
  logic [63:0] rdata;
  logic        rvalid;
  logic [63:0] hit;
  logic        hit_stb;
  logic [5:0]  thresh;
  logic        cnt_reset;
  logic        inject;
  logic        diag_on;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          crst_n = 0;
  int          inj_n = 0;
  int          c0;
  int          i0;
  logic [2:0]  tops [3] = '{hmcf_pkg::OP_NOP, hmcf_pkg::OP_CRST, hmcf_pkg::OP_INJ};
  localparam logic [63:0] MSK = 64'hF0F0_F0F0_0F0F_FFFF;
  localparam logic [63:0] PAT = 64'hFFFF_0000_FFFF_00FF;
  localparam logic [63:0] DG  = 64'h0123_4567_89AB_CDEF;

  hmcf_link_if lnk ();

  hmcf_device u_hmcf_device (.CLK_SYS(clk_sys), .RESETN(resetn), .CE(1'b1), .LINK(lnk),
    .DISC_IN(disc_in), .HIT(hit), .HIT_STB(hit_stb), .THRESH(thresh),
    .CNT_RESET(cnt_reset), .INJECT(inject), .DIAG_ON(diag_on));

  hmcf_controller u_hmcf_controller (.CLK_SYS(clk_sys), .RESETN(resetn), .CE(1'b1),
    .LINK(lnk), .REQ(req), .OPCODE(opcode), .DATA(data), .READY(ready), .DONE(done),
    .RDATA(rdata), .RVALID(rvalid));

  hmcf_link_chk u_chk (.CLK_SYS(clk_sys), .RESETN(resetn), .link_clk(lnk.link_clk),
    .link_cmd(lnk.link_cmd), .link_rsp(lnk.link_rsp));

  // 8 ns system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // pulse counters, sampled mid-cycle; a pulse standing two cycles would count twice
  always @(negedge clk_sys)
  begin
    if (cnt_reset === 1'b1) crst_n++;
    if (inject === 1'b1) inj_n++;
  end

  task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    checks_done++;
    if (s !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one frame: request held to the edge that takes it, then wait for DONE
  task automatic send(input logic [2:0] op, input logic [63:0] d);
    int n;
    n = 0;
    chk("ready", 64'(ready), 64'h1);
    req = 1'b1;
    opcode = op;
    data = d;
    @(posedge clk_sys);
    @(negedge clk_sys);
    req = 1'b0;
    while (done !== 1'b1 && n < 3000)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk("done", 64'(done), 64'h1);
    chk("rvalid", 64'(rvalid), 64'(op == hmcf_pkg::OP_READ));
    @(negedge clk_sys);
  endtask

  // bounded wait for the next hit strobe, sampled mid-cycle
  task automatic wait_stb;
    int n;
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (hit_stb !== 1'b1 && n < 40);
    chk("hit_stb", 64'(hit_stb), 64'h1);
  endtask

  initial
  begin
    resetn = 1'b0;
    req = 1'b0;
    opcode = 3'h0;
    data = 64'h0;
    disc_in = 64'h0;
    repeat (4) @(negedge clk_sys);
    resetn = 1'b1;
    chk("thresh", 64'(thresh), 64'(hmcf_pkg::THR_RST));
    chk("diag_on", 64'(diag_on), 64'h0);
    chk("hit", hit, 64'h0);
    // keep the command line quiet for the first cycles after reset
    repeat (8) @(negedge clk_sys);
    send(hmcf_pkg::OP_READ, 64'h0);
    chk("rdata", rdata, hmcf_pkg::MASK_RST);
    $display("test reset done");
    send(hmcf_pkg::OP_MASK, MSK);
    send(hmcf_pkg::OP_READ, 64'h0);
    chk("rdata", rdata, MSK);
    // only the low six data bits belong to the threshold
    send(hmcf_pkg::OP_THR, 64'hFFFF_FFFF_FFFF_FFEA);
    chk("thresh", 64'(thresh), 64'h2A);
    $display("test settings done");
    for (int i = 0; i < 3; i++)
    begin
      c0 = crst_n;
      i0 = inj_n;
      send(tops[i], 64'h0);
      chk("cnt_reset", 64'(crst_n - c0), 64'(tops[i] == hmcf_pkg::OP_CRST));
      chk("inject", 64'(inj_n - i0), 64'(tops[i] == hmcf_pkg::OP_INJ));
    end
    $display("test timing done");
    // raise inputs just after a tick so the synchroniser settles first
    wait_stb();
    disc_in = PAT;
    wait_stb();
    chk("hit", hit, PAT & MSK);
    wait_stb();
    chk("hit", hit, 64'h0);
    disc_in = 64'h0;
    $display("test hits done");
    send(hmcf_pkg::OP_DIAG, DG);
    send(hmcf_pkg::OP_DIAGEN, 64'h1);
    chk("diag_on", 64'(diag_on), 64'h1);
    repeat (2)
    begin
      wait_stb();
      chk("hit", hit, DG & MSK);
    end
    send(hmcf_pkg::OP_DIAGEN, 64'h0);
    chk("diag_on", 64'(diag_on), 64'h0);
    $display("test diag done");
    print_verdict();
  end

  // watchdog well beyond the longest expected run
  initial
  begin
    #400000;
    error_cnt++;
    print_verdict();
  end
endmodule
`default_nettype wire
